// ### dv/fsc_host_model.sv
// fsc_host_model: mode-0 serial host for the flash link
// assumes the bench issues one frame at a time through task frame
`timescale 1ns/1ps
module fsc_host_model (
    output logic linkClk,
    output logic chipSelectN,
    output logic serialIn,
    input wire logic serialOut,
    input wire logic serialOutEn
);
    initial begin
        linkClk = 1'b0;
        chipSelectN = 1'b0;
        serialIn = 1'b0;
        // one deselect edge clears the link side, which has no reset
        #2 chipSelectN = 1'b1;
    end
    // clock stands low between frames; word goes msb first
    task automatic frame(input logic [31:0] word, input int nBits,
            input int readBits, output logic [7:0] rxByte);
        int i;
        rxByte = 8'h00;
        chipSelectN = 1'b0;
        for (i = 0; i < nBits + readBits; i++) begin
            serialIn = (i < nBits) ? word[31-i] : ~serialIn;
            #7.5 linkClk = 1'b1;
            if (i >= nBits) begin
                // an undriven line reads as the inverse of the current serialOut
                rxByte = {rxByte[6:0],
                    serialOutEn ? serialOut : ~serialOut};
            end
            #7.5 linkClk = 1'b0;
        end
        #7.5 chipSelectN = 1'b1;
        serialIn = ~serialIn;
        // deselect gap longer than the core needs to take the frame
        #60;
    endtask
endmodule

// ### dv/tb_top.sv
// tb_top: self-checking bench of the flash status/config registers
// assumes fsc_host_model drives the link; timings shortened by parameters
`timescale 1ns/1ps
module tb_top;
    import fsc_pkg::*;
    logic core_clk, reset, linkClk, chipSelectN, serialIn;
    logic serialOut, serialOutEn, hwLock, holdActive, quadOk;
    logic [3:2] upperIoLanesIn;
    logic [3:0] dualDummy, quadDummy;
    fsc_status_t flashStatus;
    fsc_config_t flashConfig;
    logic [31:0] seed;
    logic [7:0] rx, lvl, exp8;
    int errTotal, testsRun, i;
    fsc_regs #(.TW_CYCLES(10), .PROGRAM_CYCLES(12), .ERASE_CYCLES(14),
        .CHIP_ERASE_CYCLES(16)) DUT (.core_clk(core_clk), .reset(reset),
        .linkClk(linkClk), .chipSelectN(chipSelectN), .serialIn(serialIn),
        .upperIoLanesIn(upperIoLanesIn), .serialOut(serialOut),
        .serialOutEn(serialOutEn), .flashStatus(flashStatus),
        .flashConfig(flashConfig), .hardwareLockState(hwLock),
        .holdActive(holdActive), .quadCmdAllowed(quadOk),
        .dualDummyCycles(dualDummy), .quadDummyCycles(quadDummy));
    fsc_host_model host (.linkClk(linkClk), .chipSelectN(chipSelectN),
        .serialIn(serialIn), .serialOut(serialOut),
        .serialOutEn(serialOutEn));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // expected protect decision: level 0 guards none, level n guards the lesser of 2^(n-1) and 4 of 4 blocks
    function automatic logic inGuard(input logic [3:0] lv, input logic bot,
            input logic [1:0] blk);
        int n;
        n = (lv == 4'h0) ? 0 : (lv > 4'h2) ? 4 : 1 << (lv - 4'h1);
        return bot ? (int'(blk) < n) : (int'(blk) >= 4 - n);
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errTotal++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen,
                exp);
        end
    endtask
    task automatic closeOut;
        $display("checks %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // negedge sync: core outputs only move on rising edges
    task automatic xfer(input logic [7:0] op, input logic [23:0] d,
            input int n, input int rd);
        host.frame({op, d}, n, rd, rx);
        @(negedge core_clk);
    endtask
    task automatic wrStat(input logic [15:0] d, input int n);
        xfer(WRITE_ENABLE_CMD, 24'h0, 8, 0);
        xfer(WRITE_STATUS_CMD, {d, 8'h00}, 8 + n, 0);
    endtask
    task automatic waitIdle;
        for (int k = 0; k < 300 && flashStatus.busyFlag !== 1'b0; k++) begin
            @(negedge core_clk);
        end
        check({7'h00, flashStatus.busyFlag}, 8'h00);
    endtask
    initial begin
        #200000;
        errTotal++;
        closeOut();
    end
    initial begin
        reset = 1'b1;
        upperIoLanesIn = 2'b11;
        seed = 32'h0000BE64;
        errTotal = 0;
        testsRun = 0;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        repeat (3) @(negedge core_clk);
        check(flashStatus, STATUS_RESET);
        check(flashConfig, CONFIG_RESET);
        check({dualDummy, quadDummy}, 8'h46);
        xfer(SECTOR_ERASE_CMD, 24'h000000, 32, 0);
        check(flashStatus, 8'h00);
        xfer(WRITE_ENABLE_CMD, 24'h0, 8, 0);
        xfer(READ_STATUS_CMD, 24'h0, 8, 16);
        check(rx, 8'h02);
        for (i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            lvl = {2'b00, seed[3:0] | 4'h1, 2'b00};
            wrStat({lvl, 8'h00}, 8);
            check(flashStatus, lvl | 8'h03);
            xfer(READ_STATUS_CMD, 24'h0, 8, 8);
            check(rx, lvl | 8'h03);
            waitIdle();
            check(flashStatus, lvl);
            xfer(WRITE_ENABLE_CMD, 24'h0, 8, 0);
            xfer(SECTOR_ERASE_CMD, 24'h030000, 32, 0);
            check(flashStatus, lvl);
            xfer(WRITE_ENABLE_CMD, 24'h0, 8, 0);
            xfer(i[1] ? BLOCK_ERASE_CMD : PAGE_PROGRAM_CMD,
                {6'h00, seed[9:8], 16'h0000}, 32, 0);
            exp8 = inGuard(lvl[5:2], 1'b0, seed[9:8]) ? lvl : lvl | 8'h03;
            check(flashStatus, exp8);
            waitIdle();
            check(flashStatus, lvl);
            xfer(WRITE_ENABLE_CMD, 24'h0, 8, 0);
            xfer(i[0] ? CHIP_ERASE_CMD : CHIP_ERASE_ALT_CMD, 24'h0, 8, 0);
            check(flashStatus, lvl);
        end
        wrStat(16'h0000, 8);
        waitIdle();
        xfer(WRITE_ENABLE_CMD, 24'h0, 8, 0);
        xfer(CHIP_ERASE_CMD, 24'h0, 8, 0);
        check(flashStatus, 8'h03);
        waitIdle();
        check(flashStatus, 8'h00);
        wrStat(16'h3C00, 12);
        check(flashStatus, 8'h02);
        wrStat(16'h40FF, 16);
        waitIdle();
        check(flashConfig, 8'h48);
        check({dualDummy, quadDummy}, 8'h8A);
        xfer(READ_CONFIG_CMD, 24'h0, 8, 8);
        check(rx, 8'h48);
        check({7'h00, serialOutEn}, 8'h00);
        @(posedge core_clk) upperIoLanesIn <= 2'h0;
        repeat (5) @(negedge core_clk);
        check({5'h00, quadOk, holdActive, hwLock}, 8'h04);
        wrStat(16'h8000, 16);
        waitIdle();
        check(flashConfig, 8'h08);
        repeat (5) @(negedge core_clk);
        check({5'h00, quadOk, holdActive, hwLock}, 8'h03);
        wrStat(16'h0000, 8);
        check(flashStatus, 8'h82);
        @(posedge core_clk) upperIoLanesIn <= 2'h3;
        repeat (5) @(negedge core_clk);
        wrStat(16'h0000, 8);
        waitIdle();
        check(flashStatus, 8'h00);
        wrStat(16'h0400, 8);
        waitIdle();
        xfer(WRITE_ENABLE_CMD, 24'h0, 8, 0);
        xfer(HALF_BLOCK_ERASE_CMD, 24'h000000, 32, 0);
        exp8 = inGuard(4'h1, 1'b1, 2'h0) ? 8'h04 : 8'h07;
        check(flashStatus, exp8);
        waitIdle();
        xfer(WRITE_ENABLE_CMD, 24'h0, 8, 0);
        xfer(QUAD_PAGE_PROGRAM_CMD, 24'h030000, 32, 0);
        check(flashStatus, 8'h06);
        xfer(WRITE_DISABLE_CMD, 24'h0, 8, 0);
        check(flashStatus, 8'h04);
        xfer(WRITE_ENABLE_CMD, 24'h0, 8, 0);
        xfer(SECTOR_ERASE_CMD, 24'h030000, 32, 0);
        exp8 = inGuard(4'h1, 1'b1, 2'h3) ? 8'h04 : 8'h07;
        check(flashStatus, exp8);
        waitIdle();
        check(flashStatus, 8'h04);
        closeOut();
    end
endmodule

// ### inc/fsc_pkg.sv
// fsc_pkg: shared types and constants of the flash status/config block
// assumes a 100 MHz core clock and a serial host in clock mode 0
package fsc_pkg;

    typedef struct packed {
        logic statusWriteLock;
        logic quadModeEnable;
        logic [3:0] protectLevelBits;
        logic writeEnableLatch;
        logic busyFlag;
    } fsc_status_t;

    typedef struct packed {
        logic reserved7;
        logic dummyCountSelect;
        logic [1:0] reserved5to4;
        logic protectFromBottom;
        logic [2:0] reserved2to0;
    } fsc_config_t;

    // one finished frame as seen by the core once chip select is high
    typedef struct packed {
        logic [7:0] opcode;
        logic [5:0] bitCount;
        logic [15:0] dataWord;
        logic [23:0] address;
    } fsc_frame_t;

    typedef enum logic [2:0] {
        FSC_IDLE = 3'b001,
        FSC_STATUS_WRITE = 3'b010,
        FSC_ARRAY_OP = 3'b100
    } fsc_state_t;

    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] CONFIG_WRITE_MASK = 8'h48;

    // instruction codes
    localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
    localparam logic [7:0] READ_STATUS_CMD = 8'h05;
    localparam logic [7:0] READ_CONFIG_CMD = 8'h15;
    localparam logic [7:0] WRITE_STATUS_CMD = 8'h01;
    localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
    localparam logic [7:0] QUAD_PAGE_PROGRAM_CMD = 8'h38;
    localparam logic [7:0] SECTOR_ERASE_CMD = 8'h20;
    localparam logic [7:0] HALF_BLOCK_ERASE_CMD = 8'h52;
    localparam logic [7:0] BLOCK_ERASE_CMD = 8'hD8;
    localparam logic [7:0] CHIP_ERASE_CMD = 8'h60;
    localparam logic [7:0] CHIP_ERASE_ALT_CMD = 8'hC7;

    // frame lengths in serial bits, opcode included
    localparam logic [5:0] OPCODE_BITS = 6'h08;
    localparam logic [5:0] STATUS_ONLY_BITS = 6'h10;
    localparam logic [5:0] STATUS_CONFIG_BITS = 6'h18;
    localparam logic [5:0] ADDRESS_END_BITS = 6'h20;

    localparam logic [3:0] DUAL_DUMMY_SHORT = 4'h4;
    localparam logic [3:0] DUAL_DUMMY_LONG = 4'h8;
    localparam logic [3:0] QUAD_DUMMY_SHORT = 4'h6;
    localparam logic [3:0] QUAD_DUMMY_LONG = 4'hA;

    localparam int CORE_CLK_MHZ = 100;
    localparam int STATUS_WRITE_TIME_NS = 10000;
    localparam int PROGRAM_TIME_NS = 20000;
    localparam int ERASE_TIME_NS = 40000;
    localparam int CHIP_ERASE_TIME_NS = 80000;
    localparam int STATUS_WRITE_CYCLES = STATUS_WRITE_TIME_NS * CORE_CLK_MHZ / 1000;
    localparam int PROGRAM_CYCLES = PROGRAM_TIME_NS * CORE_CLK_MHZ / 1000;
    localparam int ERASE_CYCLES = ERASE_TIME_NS * CORE_CLK_MHZ / 1000;
    localparam int CHIP_ERASE_CYCLES = CHIP_ERASE_TIME_NS * CORE_CLK_MHZ / 1000;
    localparam int TIMER_W = 16;

endpackage

// ### verilog/fsc_busy_timer.sv
// fsc_busy_timer: self-timed interval counter behind the busy flag
// assumes start is a one-cycle pulse on core_clk and loadCount >= 1
`timescale 1ns/1ps
module fsc_busy_timer #(
    parameter int TIMER_W = 16
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [TIMER_W-1:0] loadCount,
    output logic running,
    output logic done
);
    logic [TIMER_W-1:0] remaining;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            remaining <= '0;
            running <= 1'b0;
        end else if (start) begin
            remaining <= loadCount;
            running <= 1'b1;
        end else if (running) begin
            remaining <= remaining - 1'b1;
            if (remaining == {{(TIMER_W-1){1'b0}}, 1'b1}) begin
                running <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            done <= 1'b0;
        end else begin
            done <= running && !start &&
                (remaining == {{(TIMER_W-1){1'b0}}, 1'b1});
        end
    end

    a_timer_length: assert property (@(posedge core_clk) disable iff (reset)
        start && loadCount > 4 |=> running [*4])
        else $error("interval ended early");

    a_done_after_run: assert property (@(posedge core_clk)
        disable iff (reset) done |-> $past(running) && !running)
        else $error("done without a finished interval");

endmodule

// ### verilog/fsc_regs.sv
// fsc_regs: status and configuration registers of a serial NOR flash
// assumes a mode-0 host; link logic runs on linkClk, the rest on core_clk
`timescale 1ns/1ps

// Summary of operation
// - status read is served anytime, busy cycles continue untouched
// - status read: opcode in, status byte out, upper lanes ignored
// - status bit 0 shows a program, erase or status write running
// - write-enable latch set by write enable; array ops need it
// - latch clears when a program or erase finishes
// - array op on protected area is dropped and clears the latch
// - bits 5..2 protect level, reset unprotected, changed by status write
// - chip erase runs only with protect level zero
// - quad enable 0: quad commands ignored, lanes 2/3 protect and hold
// - quad enable 1: all commands, protect and hold functions off
// - lock bit with protect pin low rejects status writes
// - config bit 3 picks bottom protect, one-time, via status write
// - config bit 6 picks dummy cycles: dual 4/8, quad 6/10
// - config read is served anytime, byte shifted out serially
// - status write runs only if frame ends after 8 or 16 data bits
// - accepted status write holds busy, then clears busy and latch
module fsc_regs
    import fsc_pkg::*;
#(
    parameter int ADDR_W = 18,
    parameter int BLOCK_W = 2,
    parameter int TW_CYCLES = fsc_pkg::STATUS_WRITE_CYCLES,
    parameter int PROGRAM_CYCLES = fsc_pkg::PROGRAM_CYCLES,
    parameter int ERASE_CYCLES = fsc_pkg::ERASE_CYCLES,
    parameter int CHIP_ERASE_CYCLES = fsc_pkg::CHIP_ERASE_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic linkClk,
    input wire logic chipSelectN,
    input wire logic serialIn,
    input wire logic [3:2] upperIoLanesIn,
    output logic serialOut,
    output logic serialOutEn,
    output fsc_pkg::fsc_status_t flashStatus,
    output fsc_pkg::fsc_config_t flashConfig,
    output logic hardwareLockState,
    output logic holdActive,
    output logic quadCmdAllowed,
    output logic [3:0] dualDummyCycles,
    output logic [3:0] quadDummyCycles
);
    import fsc_pkg::*;

    localparam logic [BLOCK_W:0] NUM_BLOCKS = {1'b1, {BLOCK_W{1'b0}}};

    // ---------------- link domain ----------------
    logic frameOpen;
    logic [5:0] bitCount;
    logic [31:0] shiftIn;
    logic [7:0] opcode;
    logic [23:0] address;
    logic [7:0] outByte;
    logic readCmdActive;

    // published copies; core holds them still while a frame is open
    fsc_status_t pubStatus;
    fsc_config_t pubConfig;

    // frame bookkeeping dies with chip select; data stays for the core
    always_ff @(posedge linkClk or posedge chipSelectN) begin
        if (chipSelectN) begin
            frameOpen <= 1'b0;
        end else begin
            frameOpen <= 1'b1;
        end
    end

    // only lane 0 is shifted in; upper lanes are don't care here
    always_ff @(posedge linkClk) begin
        if (!frameOpen) begin
            bitCount <= 6'h01;
            shiftIn <= {31'h0000_0000, serialIn};
        end else begin
            if (bitCount != 6'h3F) begin
                bitCount <= bitCount + 6'h01;
            end
            shiftIn <= {shiftIn[30:0], serialIn};
        end
    end

    always_ff @(posedge linkClk) begin
        if (frameOpen && bitCount == OPCODE_BITS - 6'h01) begin
            opcode <= {shiftIn[6:0], serialIn};
        end
    end

    always_ff @(posedge linkClk) begin
        if (frameOpen && bitCount == ADDRESS_END_BITS - 6'h01) begin
            address <= {shiftIn[22:0], serialIn};
        end
    end

    always_comb begin
        readCmdActive = frameOpen && bitCount >= OPCODE_BITS &&
            (opcode == READ_STATUS_CMD || opcode == READ_CONFIG_CMD);
        outByte = (opcode == READ_CONFIG_CMD) ? pubConfig : pubStatus;
    end

    // falling edge drive, msb first, byte repeats until the bit count sticks at 63
    always_ff @(negedge linkClk or posedge chipSelectN) begin
        if (chipSelectN) begin
            serialOut <= 1'b0;
            serialOutEn <= 1'b0;
        end else if (readCmdActive) begin
            serialOut <= outByte[~bitCount[2:0]];
            serialOutEn <= 1'b1;
        end else begin
            serialOut <= 1'b0;
            serialOutEn <= 1'b0;
        end
    end

    // ---------------- core domain ----------------
    logic csMeta;
    logic csSync;
    logic csPrev;
    logic [3:2] laneMeta;
    logic [3:2] laneSync;
    logic frameEnd;
    fsc_frame_t frame;
    fsc_state_t state;
    fsc_state_t next_state;
    logic timerStart;
    logic [TIMER_W-1:0] timerLoad;
    logic timerRunning;
    logic timerDone;
    logic hwLockNow;
    logic isArrayCmd;
    logic isChipErase;
    logic isStatusWrite;
    logic isReadCmd;
    logic lengthOk;
    logic areaHit;
    logic acceptStatusWrite;
    logic acceptArray;
    logic dropProtected;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            csMeta <= 1'b1;
            csSync <= 1'b1;
            csPrev <= 1'b1;
            laneMeta <= 2'h3;
            laneSync <= 2'h3;
        end else begin
            csMeta <= chipSelectN;
            csSync <= csMeta;
            csPrev <= csSync;
            laneMeta <= upperIoLanesIn;
            laneSync <= laneMeta;
        end
    end

    function automatic logic inProtected(
        input logic [3:0] level,
        input logic fromBottom,
        input logic [BLOCK_W-1:0] block
    );
        logic [BLOCK_W:0] guarded;
        guarded = '0;
        if (level != 4'h0) begin
            if (32'(level) > BLOCK_W) begin
                guarded = NUM_BLOCKS;
            end else begin
                guarded = (BLOCK_W+1)'(1) << (level - 4'h1);
            end
        end
        if (fromBottom) begin
            inProtected = {1'b0, block} < guarded;
        end else begin
            inProtected = {1'b0, block} >= NUM_BLOCKS - guarded;
        end
    endfunction

    // frame words are read only after chip select rose, when linkClk
    // is quiet, so they are stable; a deselect gap of 3 core cycles is
    // the price of this cheap crossing
    always_comb begin
        frameEnd = csSync && !csPrev;
        frame = {opcode, bitCount, shiftIn[15:0], address};
        hwLockNow = flashStatus.statusWriteLock && !laneSync[2] &&
            !flashStatus.quadModeEnable;
        isStatusWrite = frame.opcode == WRITE_STATUS_CMD;
        isChipErase = frame.opcode == CHIP_ERASE_CMD ||
            frame.opcode == CHIP_ERASE_ALT_CMD;
        isArrayCmd = frame.opcode == PAGE_PROGRAM_CMD ||
            frame.opcode == SECTOR_ERASE_CMD ||
            frame.opcode == HALF_BLOCK_ERASE_CMD ||
            frame.opcode == BLOCK_ERASE_CMD ||
            (frame.opcode == QUAD_PAGE_PROGRAM_CMD &&
            flashStatus.quadModeEnable);
        isReadCmd = frame.opcode == READ_STATUS_CMD ||
            frame.opcode == READ_CONFIG_CMD;
        lengthOk = frame.bitCount == STATUS_ONLY_BITS ||
            frame.bitCount == STATUS_CONFIG_BITS;
        areaHit = inProtected(flashStatus.protectLevelBits,
            flashConfig.protectFromBottom,
            frame.address[ADDR_W-1 -: BLOCK_W]);
        acceptStatusWrite = frameEnd && state == FSC_IDLE &&
            isStatusWrite && flashStatus.writeEnableLatch &&
            !hwLockNow && lengthOk;
        dropProtected = frameEnd && state == FSC_IDLE &&
            flashStatus.writeEnableLatch &&
            ((isArrayCmd && frame.bitCount >= ADDRESS_END_BITS &&
            areaHit) ||
            (isChipErase && flashStatus.protectLevelBits != 4'h0));
        acceptArray = frameEnd && state == FSC_IDLE &&
            flashStatus.writeEnableLatch && !dropProtected &&
            ((isArrayCmd && frame.bitCount >= ADDRESS_END_BITS) ||
            isChipErase);
    end

    always_comb begin
        next_state = state;
        timerStart = 1'b0;
        timerLoad = TIMER_W'(TW_CYCLES);
        unique case (state)
            FSC_IDLE: begin
                if (acceptStatusWrite) begin
                    next_state = FSC_STATUS_WRITE;
                    timerStart = 1'b1;
                end else if (acceptArray) begin
                    next_state = FSC_ARRAY_OP;
                    timerStart = 1'b1;
                    if (isChipErase) begin
                        timerLoad = TIMER_W'(CHIP_ERASE_CYCLES);
                    end else if (frame.opcode == PAGE_PROGRAM_CMD ||
                        frame.opcode == QUAD_PAGE_PROGRAM_CMD) begin
                        timerLoad = TIMER_W'(PROGRAM_CYCLES);
                    end else begin
                        timerLoad = TIMER_W'(ERASE_CYCLES);
                    end
                end
            end
            FSC_STATUS_WRITE, FSC_ARRAY_OP: begin
                if (timerDone) begin
                    next_state = FSC_IDLE;
                end
            end
            default: next_state = FSC_IDLE;
        endcase
    end

    // reads never touch the running cycle; other commands are dropped unless idle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= FSC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    fsc_busy_timer #(
        .TIMER_W(TIMER_W)
    ) u_busy_timer (
        .core_clk(core_clk),
        .reset(reset),
        .start(timerStart),
        .loadCount(timerLoad),
        .running(timerRunning),
        .done(timerDone)
    );

    always_ff @(posedge core_clk) begin
        if (reset) begin
            flashStatus <= STATUS_RESET;
        end else begin
            flashStatus.busyFlag <= next_state != FSC_IDLE;
            if (timerDone || dropProtected) begin
                flashStatus.writeEnableLatch <= 1'b0;
            end else if (frameEnd && state == FSC_IDLE &&
                frame.bitCount == OPCODE_BITS) begin
                if (frame.opcode == WRITE_ENABLE_CMD) begin
                    flashStatus.writeEnableLatch <= 1'b1;
                end else if (frame.opcode == WRITE_DISABLE_CMD) begin
                    flashStatus.writeEnableLatch <= 1'b0;
                end
            end
            if (acceptStatusWrite) begin
                if (frame.bitCount == STATUS_ONLY_BITS) begin
                    flashStatus[7:2] <= frame.dataWord[7:2];
                end else begin
                    flashStatus[7:2] <= frame.dataWord[15:10];
                end
            end
        end
    end

    // one-time bit only ever sets; reserved bits stay zero
    always_ff @(posedge core_clk) begin
        if (reset) begin
            flashConfig <= CONFIG_RESET;
        end else if (acceptStatusWrite &&
            frame.bitCount == STATUS_CONFIG_BITS) begin
            flashConfig <= (frame.dataWord[7:0] & CONFIG_WRITE_MASK) |
                (flashConfig & 8'h08);
        end
    end

    // copies refresh only while deselected so a read sees one byte
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pubStatus <= STATUS_RESET;
            pubConfig <= CONFIG_RESET;
        end else if (csSync) begin
            pubStatus <= flashStatus;
            pubConfig <= flashConfig;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            hardwareLockState <= 1'b0;
            holdActive <= 1'b0;
            quadCmdAllowed <= 1'b0;
            dualDummyCycles <= DUAL_DUMMY_SHORT;
            quadDummyCycles <= QUAD_DUMMY_SHORT;
        end else begin
            hardwareLockState <= hwLockNow;
            holdActive <= !flashStatus.quadModeEnable &&
                !laneSync[3];
            quadCmdAllowed <= flashStatus.quadModeEnable;
            dualDummyCycles <= flashConfig.dummyCountSelect ?
                DUAL_DUMMY_LONG : DUAL_DUMMY_SHORT;
            quadDummyCycles <= flashConfig.dummyCountSelect ?
                QUAD_DUMMY_LONG : QUAD_DUMMY_SHORT;
        end
    end

    a_busy_follows_state: assert property (@(posedge core_clk)
        disable iff (reset)
        timerStart |=> flashStatus.busyFlag [*3])
        else $error("busy flag missing during cycle");

    a_done_clears_wel: assert property (@(posedge core_clk)
        disable iff (reset)
        timerDone |=> !flashStatus.writeEnableLatch &&
        !flashStatus.busyFlag)
        else $error("latch or busy left set after completion");

    a_ignore_no_wel: assert property (@(posedge core_clk)
        disable iff (reset)
        frameEnd && state == FSC_IDLE && !flashStatus.writeEnableLatch &&
        (isArrayCmd || isChipErase) |=> state == FSC_IDLE)
        else $error("array command ran without write enable");

    a_protect_drop: assert property (@(posedge core_clk)
        disable iff (reset)
        dropProtected |=> !flashStatus.writeEnableLatch &&
        state == FSC_IDLE)
        else $error("protected area command not dropped");

    a_chip_erase_gate: assert property (@(posedge core_clk)
        disable iff (reset)
        frameEnd && isChipErase && flashStatus.protectLevelBits != 4'h0
        |=> !flashStatus.busyFlag || $past(flashStatus.busyFlag))
        else $error("chip erase ran while protected");

    a_write_status_cmd_length: assert property (@(posedge core_clk)
        disable iff (reset)
        frameEnd && isStatusWrite && !lengthOk
        |=> $stable(flashStatus[7:2]))
        else $error("odd length status write changed bits");

    a_lock_rejects: assert property (@(posedge core_clk)
        disable iff (reset)
        frameEnd && isStatusWrite && hwLockNow
        |=> $stable(flashStatus[7:2]) && $stable(flashConfig))
        else $error("locked status write took effect");

    a_read_undisturbed: assert property (@(posedge core_clk)
        disable iff (reset)
        frameEnd && isReadCmd && !timerDone
        |=> $stable(state) && $stable(flashStatus))
        else $error("register read disturbed the cycle");

    a_reserved_zero: assert property (@(posedge core_clk)
        disable iff (reset)
        flashConfig.reserved7 == 1'b0 && flashConfig.reserved5to4 == 2'h0
        && flashConfig.reserved2to0 == 3'h0)
        else $error("reserved config bit set");

    a_dummy_select: assert property (@(posedge core_clk)
        disable iff (reset)
        $rose(flashConfig.dummyCountSelect)
        |=> dualDummyCycles == 4'h8 && quadDummyCycles == 4'hA)
        else $error("dummy count not switched");

    a_quad_no_hold: assert property (@(posedge core_clk)
        disable iff (reset)
        flashStatus.quadModeEnable [*2] |-> !holdActive)
        else $error("hold active in quad mode");

    a_output_stops: assert property (@(posedge core_clk)
        disable iff (reset)
        csSync |-> !serialOutEn)
        else $error("output driven while deselected");

endmodule
